// [verilog/ipdc_pkg.sv]
// Purpose: Shared constants of the interleaved posted-write DRAM sequencer
// Assumes: 100 MHz processor bus clock
// Notes: Row hold count derives from named times; write strobe lag is a plain count
package ipdc_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned ROW_HOLD_NS = 20;
   // Least time, rounded up to whole cycles
   localparam int unsigned ROW_HOLD_CYC = (ROW_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] ROW_HOLD_CNT = 2'(ROW_HOLD_CYC);
   // Write column strobe lags write ack by this many clocks
   localparam int unsigned WR_CAS_LAG = 2;

   // ----------------------------------------------------------------
   // Burst, buffer and cache enable reset
   // ----------------------------------------------------------------
   localparam logic [1:0] BEAT_FIRST = 2'h0;
   localparam logic [1:0] BUF_DEPTH = 2'h2;
   localparam logic KEN_RESET = 1'h0;

   // ----------------------------------------------------------------
   // Cycle sequencer states, Gray coded along the usual path
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_WAIT = 3'h1,
      ST_ROW = 3'h3,
      ST_CAS = 3'h2,
      ST_BURST = 3'h6,
      ST_WACK = 3'h4
   } ipdc_state_e;

endpackage : ipdc_pkg

// [verilog/ipdc_ctrl.sv]
// Purpose: Read burst and posted write sequencing for a two-bank DRAM
// Assumes: All inputs synchronous to clk_i except the cacheable decode
// Notes: Precharge, refresh arbitration and write-read delay live outside
//
// Behaviour
// - Row strobe already on except after reset/refresh/read miss
// - Address strobe sets address hold, cycle active
// - Second wait state samples select, hit; raises row
// - Delayed row strobe lags 20 ns; column select
// - Reads keep write path disabled
// - Row-off read: column third, ack fourth wait
// - Burst address predicted in second wait state
// - Second word switches select, strobes drop
// - Same row keeps row strobe on
// - Page hit: strobes and ack second wait
// - Separate paths; A3 latched every cycle
// - Cache enable valid at second wait state
// - Cache enable via two-clock synchroniser, normally on
// - Burst last ends burst ack
// - Write sampled: write path, enables, write ack
// - Write address in pipeline clock after enable
// - Write data captured into both banks
// - Both write enables; bank strobe two clocks later
// - Row-off write ends at processor in three
// - Row-on write ack clock after address strobe
// - Zero-wait write spans four clocks, overlaps
// - Back-to-back writes zero wait, any bank
// - Select is synchronous decoder output
module ipdc_ctrl #(
   parameter int unsigned ADDR_W = 20,
   parameter int unsigned DATA_W = 32
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic addr_strobe_n_i,
   input wire logic write_dir_i,
   input wire logic burst_last_n_i,
   input wire logic dram_select_n_i,
   input wire logic row_hit_n_i,
   input wire logic refresh_ack_i,
   input wire logic cacheable_n_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic addr_a2_i,
   input wire logic addr_a3_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic [DATA_W-1:0] dram_rdata_i,
   input wire logic rdata_ready_i,
   output logic address_hold_o,
   output logic cycle_active_n_o,
   output logic row_strobe_n_o,
   output logic delayed_row_strobe_n_o,
   output logic [ADDR_W/2-1:0] mux_addr_o,
   output logic write_path_enable_n_o,
   output logic col_strobe_bank0_n_o,
   output logic col_strobe_bank1_n_o,
   output logic burst_a3_bank0_o,
   output logic burst_a3_bank1_o,
   output logic word_select_o,
   output logic mem_burst_ack_n_o,
   output logic mem_write_ack_n_o,
   output logic bank0_write_en_n_o,
   output logic bank1_write_en_n_o,
   output logic [DATA_W-1:0] bank0_wdata_o,
   output logic [DATA_W-1:0] bank1_wdata_o,
   output logic write_pending_n_o,
   output logic cache_enable_n_o,
   output logic [DATA_W-1:0] rdata_o,
   output logic rdata_valid_o
);

   localparam int unsigned MA_W = ADDR_W / 2;
   // Local names of the package's sequencer states
   localparam ipdc_pkg::ipdc_state_e ST_IDLE = ipdc_pkg::ST_IDLE;
   localparam ipdc_pkg::ipdc_state_e ST_WAIT = ipdc_pkg::ST_WAIT;
   localparam ipdc_pkg::ipdc_state_e ST_ROW = ipdc_pkg::ST_ROW;
   localparam ipdc_pkg::ipdc_state_e ST_CAS = ipdc_pkg::ST_CAS;
   localparam ipdc_pkg::ipdc_state_e ST_BURST = ipdc_pkg::ST_BURST;
   localparam ipdc_pkg::ipdc_state_e ST_WACK = ipdc_pkg::ST_WACK;

   ipdc_pkg::ipdc_state_e state_q;
   logic hold_q, row_on_q, dir_q, a2_q, a3_q, ack_q, wack_q, ws1_v_q, ws1_b_q;
   logic col_strobe_bank0_n_q, col_strobe_bank1_n_q, wcas_q, wpe_q, col_sel_q, wsel_q, a3b0_q, a3b1_q;
   logic [1:0] drow_cnt_q, beat_q;
   logic [ADDR_W-1:0] lat_addr_q;
   logic [MA_W-1:0] wr_pipe_q, mux_q;
   logic [DATA_W-1:0] wd0_q, wd1_q, head_q, tail_q;
   logic head_v_q, tail_v_q, ken_meta_q, ken_q;
   logic ads, pop, room, beat_end;
   logic [1:0] cnt_next;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [MA_W-1:0] col_part(input logic [ADDR_W-1:0] a);
      col_part = a[MA_W-1:0];
   endfunction : col_part

   function automatic logic [MA_W-1:0] row_part(input logic [ADDR_W-1:0] a);
      row_part = a[ADDR_W-1:MA_W];
   endfunction : row_part

   // Cycle start only when idle and address strobe low
   assign ads = (state_q == ST_IDLE) && !addr_strobe_n_i;
   assign pop = head_v_q && rdata_ready_i;
   assign cnt_next = 2'({1'b0, head_v_q} + {1'b0, tail_v_q} + {1'b0, ack_q} - {1'b0, pop});
   assign room = cnt_next < ipdc_pkg::BUF_DEPTH;
   assign beat_end = ack_q && !burst_last_n_i;

   // ----------------------------------------------------------------
   // Cycle sequencer
   // ----------------------------------------------------------------
   // State, hold, cycle active and burst ack
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q <= ST_IDLE;
         hold_q <= 1'b0;
         ack_q <= 1'b0;
         wack_q <= 1'b0;
      end else begin
         wack_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (ads) begin
                  hold_q <= 1'b1;
                  if (write_dir_i && row_on_q && !dram_select_n_i) begin
                     wack_q <= 1'b1;
                     state_q <= ST_WACK;
                  end else begin
                     state_q <= ST_WAIT;
                  end
               end
            end
            ST_WAIT: begin
               if (dram_select_n_i) begin
                  hold_q <= 1'b0;
                  state_q <= ST_IDLE;
               end else if (dir_q) begin
                  wack_q <= 1'b1;
                  state_q <= ST_WACK;
               end else if (row_on_q && !row_hit_n_i) begin
                  ack_q <= room;
                  state_q <= ST_BURST;
               end else begin
                  state_q <= ST_ROW;
               end
            end
            ST_ROW: state_q <= ST_CAS;
            ST_CAS: begin
               ack_q <= room;
               state_q <= ST_BURST;
            end
            ST_BURST: begin
               if (beat_end) begin
                  ack_q <= 1'b0;
                  hold_q <= 1'b0;
                  state_q <= ST_IDLE;
               end else begin
                  ack_q <= room;
               end
            end
            ST_WACK: begin
               hold_q <= 1'b0;
               state_q <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Row strobe stays on between cycles, dropped by refresh or read miss
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         row_on_q <= 1'b0;
      end else if (state_q == ST_IDLE && refresh_ack_i) begin
         row_on_q <= 1'b0;
      end else if (state_q == ST_WAIT && !dram_select_n_i) begin
         row_on_q <= row_on_q ? !row_hit_n_i || dir_q : 1'b1;
      end
   end

   // Delayed row strobe and column address select
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         drow_cnt_q <= 2'h0;
         col_sel_q <= 1'b0;
      end else if (!row_on_q) begin
         drow_cnt_q <= 2'h0;
         col_sel_q <= 1'b0;
      end else if (drow_cnt_q < ipdc_pkg::ROW_HOLD_CNT - 2'h1) begin
         drow_cnt_q <= drow_cnt_q + 2'h1;
      end else begin
         col_sel_q <= 1'b1;
      end
   end

   // Address, direction and A3 latch under address hold
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         lat_addr_q <= '0;
         dir_q <= 1'b0;
         a2_q <= 1'b0;
         a3_q <= 1'b0;
      end else if (ads) begin
         lat_addr_q <= addr_i;
         dir_q <= write_dir_i;
         a2_q <= addr_a2_i;
         a3_q <= addr_a3_i;
      end
   end

   // ----------------------------------------------------------------
   // Read burst addressing and strobes
   // ----------------------------------------------------------------
   // Prediction, word select and read column strobes
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         a3b0_q <= 1'b0;
         a3b1_q <= 1'b0;
         wsel_q <= 1'b0;
         beat_q <= ipdc_pkg::BEAT_FIRST;
         col_strobe_bank0_n_q <= 1'b0;
         col_strobe_bank1_n_q <= 1'b0;
      end else begin
         if (state_q == ST_WAIT && !dir_q) begin
            a3b0_q <= a3_q;
            a3b1_q <= a3_q;
            wsel_q <= a2_q;
            beat_q <= ipdc_pkg::BEAT_FIRST;
            col_strobe_bank0_n_q <= row_on_q && !row_hit_n_i && !dram_select_n_i;
            col_strobe_bank1_n_q <= row_on_q && !row_hit_n_i && !dram_select_n_i;
         end else if (state_q == ST_ROW) begin
            col_strobe_bank0_n_q <= 1'b1;
            col_strobe_bank1_n_q <= 1'b1;
         end else if (state_q == ST_BURST) begin
            if (beat_end) begin
               col_strobe_bank0_n_q <= 1'b0;
               col_strobe_bank1_n_q <= 1'b0;
            end else if (ack_q) begin
               beat_q <= beat_q + 2'h1;
               wsel_q <= !wsel_q;
               if (beat_q == ipdc_pkg::BEAT_FIRST) begin
                  a3b0_q <= !a3b0_q;
                  a3b1_q <= !a3b1_q;
                  col_strobe_bank0_n_q <= 1'b0;
                  col_strobe_bank1_n_q <= 1'b0;
               end else begin
                  col_strobe_bank0_n_q <= 1'b1;
                  col_strobe_bank1_n_q <= 1'b1;
               end
            end else begin
               col_strobe_bank0_n_q <= 1'b1;
               col_strobe_bank1_n_q <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Posted write engine
   // ----------------------------------------------------------------
   // Two-stage pipeline gives bank strobe two clocks after ack
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ws1_v_q <= 1'b0;
         ws1_b_q <= 1'b0;
         wcas_q <= 1'b0;
      end else begin
         ws1_v_q <= wack_q;
         ws1_b_q <= a2_q;
         wcas_q <= ws1_v_q;
      end
   end

   // Write path enable and write enables held while writes pend
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wpe_q <= 1'b0;
      end else begin
         wpe_q <= (state_q == ST_WAIT && dir_q && !dram_select_n_i) || (ads && write_dir_i
            && row_on_q && !dram_select_n_i) || wack_q || ws1_v_q;
      end
   end

   // Write address pipeline and data registers of both banks
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_pipe_q <= '0;
         wd0_q <= '0;
         wd1_q <= '0;
      end else if (wack_q) begin
         wr_pipe_q <= col_part(lat_addr_q);
         wd0_q <= wdata_i;
         wd1_q <= wdata_i;
      end
   end

   // Multiplexed DRAM address: write pipeline, column or row
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mux_q <= '0;
      end else if (wpe_q) begin
         mux_q <= wr_pipe_q;
      end else if (col_sel_q) begin
         mux_q <= col_part(lat_addr_q);
      end else begin
         mux_q <= row_part(lat_addr_q);
      end
   end

   // ----------------------------------------------------------------
   // Cache enable synchroniser
   // ----------------------------------------------------------------
   // Two flops, resets to the active level
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ken_meta_q <= ipdc_pkg::KEN_RESET;
         ken_q <= ipdc_pkg::KEN_RESET;
      end else begin
         ken_meta_q <= cacheable_n_i;
         ken_q <= ken_meta_q;
      end
   end

   // ----------------------------------------------------------------
   // Read data buffer, two entries
   // ----------------------------------------------------------------
   // Head feeds the output; tail absorbs a word during a stall
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         head_q <= '0;
         tail_q <= '0;
         head_v_q <= 1'b0;
         tail_v_q <= 1'b0;
      end else if (!head_v_q || pop) begin
         if (tail_v_q) begin
            head_q <= tail_q;
            head_v_q <= 1'b1;
            tail_v_q <= ack_q;
            if (ack_q) begin
               tail_q <= dram_rdata_i;
            end
         end else begin
            head_v_q <= ack_q;
            if (ack_q) begin
               head_q <= dram_rdata_i;
            end
         end
      end else if (ack_q) begin
         tail_q <= dram_rdata_i;
         tail_v_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign address_hold_o = hold_q;
   assign cycle_active_n_o = !hold_q;
   assign row_strobe_n_o = !row_on_q;
   assign delayed_row_strobe_n_o = !col_sel_q;
   assign mux_addr_o = mux_q;
   assign write_path_enable_n_o = !wpe_q;
   assign col_strobe_bank0_n_o = !(col_strobe_bank0_n_q || (wcas_q && !ws1_b_q));
   assign col_strobe_bank1_n_o = !(col_strobe_bank1_n_q || (wcas_q && ws1_b_q));
   assign burst_a3_bank0_o = a3b0_q;
   assign burst_a3_bank1_o = a3b1_q;
   assign word_select_o = wsel_q;
   assign mem_burst_ack_n_o = !ack_q;
   assign mem_write_ack_n_o = !wack_q;
   assign bank0_write_en_n_o = !wpe_q;
   assign bank1_write_en_n_o = !wpe_q;
   assign bank0_wdata_o = wd0_q;
   assign bank1_wdata_o = wd1_q;
   assign write_pending_n_o = !(wpe_q || wcas_q);
   assign cache_enable_n_o = ken_q;
   assign rdata_o = head_q;
   assign rdata_valid_o = head_v_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   chk_hold_on_start: assert property (ads |=> hold_q)
      else $error("address hold not set after strobe");
   chk_row_raise: assert property (state_q == ST_WAIT && !dir_q && !row_on_q
      && !dram_select_n_i |=> row_on_q)
      else $error("row strobe not raised");
   chk_col_lag: assert property ($rose(row_on_q) |-> !col_sel_q ##1 !col_sel_q
      ##1 col_sel_q)
      else $error("delayed row strobe timing wrong");
   chk_read_path: assert property (state_q == ST_CAS |-> !wpe_q)
      else $error("write path enabled during read");
   chk_miss_read: assert property (state_q == ST_ROW |=> col_strobe_bank0_n_q && col_strobe_bank1_n_q
      ##1 ack_q || !$past(room))
      else $error("row-off read strobe order wrong");
   chk_hit_read: assert property (state_q == ST_WAIT && !dir_q && row_on_q
      && !row_hit_n_i && !dram_select_n_i && room |=> col_strobe_bank0_n_q && ack_q)
      else $error("page hit read not immediate");
   chk_word_switch: assert property (state_q == ST_BURST && ack_q && burst_last_n_i
      && beat_q == ipdc_pkg::BEAT_FIRST |=> wsel_q != $past(wsel_q) && !col_strobe_bank0_n_q)
      else $error("second word switch wrong");
   chk_burst_end: assert property (beat_end |=> !ack_q)
      else $error("burst ack after burst last");
   chk_write_cas: assert property (wack_q |-> ##2 (!col_strobe_bank0_n_o
      || !col_strobe_bank1_n_o) ##1 1'b1)
      else $error("write column strobe not two clocks after ack");
   chk_write_data: assert property (wack_q |=> wd0_q == $past(wdata_i)
      && wd1_q == wd0_q)
      else $error("write data not in both banks");
   chk_zero_wait: assert property (ads && write_dir_i && row_on_q && !dram_select_n_i
      |=> wack_q)
      else $error("row-on write not zero wait");
   chk_buf_bound: assert property (!(head_v_q && tail_v_q && ack_q && !pop))
      else $error("read buffer overrun");

   cov_hit_burst: cover property (state_q == ST_BURST && beat_end && row_on_q);
   cov_back_writes: cover property (wack_q ##2 wack_q);
   cov_stall: cover property (head_v_q && tail_v_q && !rdata_ready_i);

endmodule : ipdc_ctrl

// [bench/ipdc_cpu_model.sv]
// Purpose: Processor side of the cycle bus for the sequencer bench
// Assumes: Start requests come only while the sequencer is idle
// Notes: Flags the last word of a burst with the acknowledge that takes it
module ipdc_cpu_model (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic start_i,
   input wire logic wr_i,
   input wire logic [2:0] beats_i,
   input wire logic mem_burst_ack_n_i,
   input wire logic mem_write_ack_n_i,
   output logic addr_strobe_n_o,
   output logic write_dir_o,
   output logic burst_last_n_o,
   output logic [2:0] words_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------------------------
   // Cycle start
   // ---------------------------------------------------------------
   // Strobe low one cycle per start, direction held for the cycle
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         addr_strobe_n_o <= 1'b1;
         write_dir_o <= 1'b0;
      end else begin
         addr_strobe_n_o <= !start_i;
         if (start_i) begin
            write_dir_o <= wr_i;
         end
      end
   end

   // ---------------------------------------------------------------
   // Burst tracking
   // ---------------------------------------------------------------
   // Words taken so far in this cycle
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         words_o <= 3'h0;
      end else if (start_i) begin
         words_o <= 3'h0;
      end else if (!mem_burst_ack_n_i || !mem_write_ack_n_i) begin
         words_o <= words_o + 3'h1;
      end
   end

   // Last word flagged while its acknowledge is awaited
   assign burst_last_n_o = (words_o != (beats_i - 3'h1));
endmodule : ipdc_cpu_model

// [bench/ipdc_ctrl_tb.sv]
// Purpose: Self-checking bench of the DRAM cycle sequencer
// Assumes: 100 MHz clock, sequencer idle between scenarios
// Notes: Processor side comes from the partner model
module ipdc_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic start = 1'b0;
   logic wr_q = 1'b0;
   logic [2:0] beats = 3'h1;
   logic [2:0] words;
   logic addr_strobe_n_i, write_dir_i, burst_last_n_i;
   logic dram_select_n_i = 1'b0;
   logic row_hit_n_i = 1'b1;
   logic refresh_ack_i = 1'b0;
   logic cacheable_n_i = 1'b0;
   logic [19:0] addr_i = 20'h12345;
   logic addr_a2_i = 1'b0;
   logic addr_a3_i = 1'b0;
   logic rdata_ready_i = 1'b1;
   logic [31:0] wdata_i = 32'h0;
   logic [31:0] dram_rdata_i = 32'h0;
   logic address_hold_o, cycle_active_n_o, row_strobe_n_o, delayed_row_strobe_n_o;
   logic write_path_enable_n_o, col_strobe_bank0_n_o, col_strobe_bank1_n_o, word_select_o;
   logic mem_burst_ack_n_o, mem_write_ack_n_o, bank0_write_en_n_o, bank1_write_en_n_o;
   logic cache_enable_n_o, rdata_valid_o;
   logic [31:0] bank0_wdata_o, bank1_wdata_o;
   logic [31:0] rdata_o, d0;
   logic [9:0] mux_addr_o, ma;
   logic burst_a3_bank0_o, burst_a3_bank1_o, write_pending_n_o;
   logic [1:0] a3s;
   int failures = 0;
   int n_tests = 0;
   int pops = 0;
   int na;
   logic [4:0] lat;
   logic [11:0] rs, drs;
   logic [3:0] ws;

   // ---------------------------------------------------------------
   // Design, partner, clock and data sources
   // ---------------------------------------------------------------
   ipdc_ctrl dut (
      .clk_i, .resetn_i, .addr_strobe_n_i, .write_dir_i, .burst_last_n_i,
      .dram_select_n_i, .row_hit_n_i, .refresh_ack_i, .cacheable_n_i, .addr_i,
      .addr_a2_i, .addr_a3_i, .wdata_i, .dram_rdata_i, .rdata_ready_i,
      .address_hold_o, .cycle_active_n_o, .row_strobe_n_o, .delayed_row_strobe_n_o,
      .mux_addr_o, .write_path_enable_n_o, .col_strobe_bank0_n_o,
      .col_strobe_bank1_n_o, .burst_a3_bank0_o, .burst_a3_bank1_o, .word_select_o,
      .mem_burst_ack_n_o, .mem_write_ack_n_o, .bank0_write_en_n_o, .bank1_write_en_n_o,
      .bank0_wdata_o, .bank1_wdata_o, .write_pending_n_o, .cache_enable_n_o,
      .rdata_o, .rdata_valid_o
   );

   ipdc_cpu_model cpu (
      .clk_i, .resetn_i, .start_i(start), .wr_i(wr_q), .beats_i(beats),
      .mem_burst_ack_n_i(mem_burst_ack_n_o), .mem_write_ack_n_i(mem_write_ack_n_o),
      .addr_strobe_n_o(addr_strobe_n_i), .write_dir_o(write_dir_i),
      .burst_last_n_o(burst_last_n_i), .words_o(words)
   );

   // Clock, 10 ns period
   always #5 clk_i = ~clk_i;

   // Memory data changes every cycle, words popped are counted
   always @(posedge clk_i) begin
      dram_rdata_i <= dram_rdata_i + 32'h0101_0101;
      if (rdata_valid_o === 1'b1 && rdata_ready_i) pops <= pops + 1;
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic stop_test();
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test

   // One processor cycle, outputs recorded for 12 clocks from the take
   task automatic run(input logic wr, input logic [2:0] nb);
      int k;
      lat = 5'h1F;
      na = 0;
      @(posedge clk_i);
      wr_q <= wr;
      beats <= nb;
      start <= 1'b1;
      @(posedge clk_i);
      start <= 1'b0;
      for (k = 0; k < 12; k++) begin
         @(posedge clk_i);
         #1;
         if (k == 0) check(32'(address_hold_o & !cycle_active_n_o), 32'h1);
         if (!wr) check(32'(write_path_enable_n_o), 32'h1);
         rs[k] = row_strobe_n_o;
         drs[k] = delayed_row_strobe_n_o;
         // First acknowledge: memory word it takes and predicted A3
         if (lat == 5'h1F && !(mem_burst_ack_n_o && mem_write_ack_n_o)) begin
            lat = 5'(k);
            d0 = dram_rdata_i;
            a3s = {burst_a3_bank0_o, burst_a3_bank1_o};
         end
         if (k == 1) ma = mux_addr_o;
         if (!mem_burst_ack_n_o && na < 4) begin
            ws[na] = word_select_o;
            na++;
         end
      end
   endtask : run

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      repeat (3) @(posedge clk_i);
      resetn_i <= 1'b1;
      #1;
      check(32'({row_strobe_n_o, col_strobe_bank0_n_o, col_strobe_bank1_n_o}), 32'h7);
      check(32'({mem_burst_ack_n_o, mem_write_ack_n_o, address_hold_o}), 32'h6);
      check(32'({cache_enable_n_o, rdata_valid_o}), 32'h0);
      $display("reset state done");
   endtask : t_reset

   task automatic t_read_rowoff();
      run(1'b0, 3'h4);
      check(32'(lat), 32'h3);
      check(32'(rs[1:0]), 32'h1);
      check(32'(drs[3:2]), 32'h1);
      check(32'(ma), 32'h48);
      check(32'(mux_addr_o), 32'h345);
      check(32'(ws[0] ^ ws[1]), 32'h1);
      check(32'({words, mem_burst_ack_n_o}), 32'h9);
      $display("read from closed row done");
   endtask : t_read_rowoff

   task automatic t_read_hit();
      row_hit_n_i <= 1'b0;
      addr_a3_i <= 1'b1;
      run(1'b0, 3'h4);
      check(32'(lat), 32'h1);
      check(32'(rs), 32'h0);
      check(32'(a3s), 32'h3);
      check(32'({burst_a3_bank0_o, burst_a3_bank1_o}), 32'h0);
      check(32'({words, mem_burst_ack_n_o}), 32'h9);
      $display("page hit read done");
   endtask : t_read_hit

   task automatic t_buffer_stall();
      int k;
      int p0;
      p0 = pops;
      rdata_ready_i <= 1'b0;
      run(1'b0, 3'h4);
      check(32'({words, rdata_valid_o}), 32'h5);
      check(rdata_o, d0);
      rdata_ready_i <= 1'b1;
      for (k = 0; k < 40 && !(words == 3'h4 && rdata_valid_o === 1'b0); k++) begin
         @(posedge clk_i);
         #1;
      end
      if (k == 40) begin
         failures++;
         stop_test();
      end
      check(32'(pops - p0), 32'h4);
      $display("read buffer stall done");
   endtask : t_buffer_stall

   // Four writes two clocks apart, banks 0 1 1 0
   task automatic t_write_b2b();
      logic [3:0] pat;
      int j;
      pat = 4'b0110;
      for (j = 0; j < 12; j++) begin
         @(posedge clk_i);
         wr_q <= 1'b1;
         beats <= 3'h1;
         start <= (j < 8 && !j[0]);
         if (j[0] && j < 8) addr_a2_i <= pat[j/2];
         if (!j[0]) wdata_i <= 32'hA500_0000 + 32'(j);
         #1;
         if (j >= 2 && j <= 9) check(32'(mem_write_ack_n_o), 32'(j[0] || j > 8));
         if (j == 2) check(32'({bank0_write_en_n_o, bank1_write_en_n_o}), 32'h0);
         if (j == 2) check(32'(write_pending_n_o), 32'h0);
         if (j[0] && j >= 3 && j <= 9) begin
            check(bank0_wdata_o, 32'hA500_0000 + 32'(j - 1));
            check(bank1_wdata_o, 32'hA500_0000 + 32'(j - 1));
         end
         if (!j[0] && j >= 4 && j <= 10) begin
            check(32'(pat[(j-4)/2] ? col_strobe_bank1_n_o : col_strobe_bank0_n_o), 32'h0);
         end
      end
      $display("back to back writes done");
   endtask : t_write_b2b

   task automatic t_refresh_write();
      @(posedge clk_i);
      refresh_ack_i <= 1'b1;
      @(posedge clk_i);
      refresh_ack_i <= 1'b0;
      run(1'b1, 3'h1);
      check(32'(lat), 32'h1);
      check(32'(row_strobe_n_o), 32'h0);
      check(32'(write_pending_n_o), 32'h1);
      $display("write after refresh done");
   endtask : t_refresh_write

   task automatic t_unselected();
      dram_select_n_i <= 1'b1;
      run(1'b0, 3'h1);
      check(32'(lat), 32'h1F);
      check(32'(cycle_active_n_o), 32'h1);
      dram_select_n_i <= 1'b0;
      $display("unselected cycle done");
   endtask : t_unselected

   task automatic t_cache_sync();
      @(posedge clk_i);
      cacheable_n_i <= 1'b1;
      @(posedge clk_i);
      #1;
      check(32'(cache_enable_n_o), 32'h0);
      @(posedge clk_i);
      #1;
      check(32'(cache_enable_n_o), 32'h1);
      @(posedge clk_i);
      cacheable_n_i <= 1'b0;
      $display("cache enable delay done");
   endtask : t_cache_sync

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      t_reset();
      t_read_rowoff();
      t_read_hit();
      t_buffer_stall();
      t_write_b2b();
      t_refresh_write();
      t_unselected();
      t_cache_sync();
      stop_test();
   end
endmodule : ipdc_ctrl_tb
